// file: design/lcdh_top.sv
// lcd row/column driver core behind the 8-bit host port
// Behaviour
// R1: cd low: command write, status read
// R2: cd high: display memory read/write
// R3: 68-type: enable high selects device
// R4: 80-type: read strobe low requests read
// R5: 68-type: direction high read, low write
// R6: 80-type: write strobe low requests write
// R7: data bus driven only during reads
// R8: after reset: bus floats, outputs at vdd
// R9: row counter scans; row level from frame
// R10: column level from frame and display bit
// R11: clock pad takes external timing clock
// R12: host drives chip select from decode
// R13: row pads become columns on slaves
// R14: reset pin edge resets, level picks mode
// R15: frame pin output on master, input slave
`timescale 1ns/1ps
`include "lcdh_defines.svh"
module lcdh_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_if_pin,
  input wire logic chip_sel,
  input wire logic cmd_data_sel,
  input wire logic strobe_e_rd,
  input wire logic dir_rw_wr,
  input wire logic master_sel,
  input wire logic ext_clock_in,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic frame_polarity_in,
  output logic frame_polarity_out,
  output logic frame_polarity_oe,
  output lcdh_pkg::lcdh_level_t row_drivers [`LCDH_ROWS],
  output lcdh_pkg::lcdh_level_t column_drivers [`LCDH_COLS]
);
  lcdh_bus_if bus ();

  logic pin_prev_q;
  logic srst_q;
  logic mode68_q;
  logic clk_prev_q;
  logic disp_on_q;
  logic [4:0] row_addr_q;
  logic [3:0] col_byte_q;
  logic [3:0] row_cnt_q;
  logic frame_q;
  logic [7:0] mem [`LCDH_MEM_ROWS][`LCDH_MEM_BYTES];
  logic pin_edge;
  logic tick;
  logic frame_use;
  logic cmd_wr;
  logic data_wr;
  logic data_rd_end;
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [3:0] row_cnt_d;

  // --------------------------------------------
  // helpers
  // --------------------------------------------
  function automatic logic [3:0] next_byte(input logic [3:0] b);
    next_byte = (b == 4'(`LCDH_MEM_BYTES - 1)) ? 4'h0 : b + 4'h1;
  endfunction

  function automatic lcdh_pkg::lcdh_level_t row_lvl(input logic fr, input logic sel);
    unique case ({fr, sel})
      2'b00: row_lvl = lcdh_pkg::lv_v4;
      2'b01: row_lvl = lcdh_pkg::lv_v5;
      2'b10: row_lvl = lcdh_pkg::lv_v1;
      2'b11: row_lvl = lcdh_pkg::lv_vdd;
    endcase
  endfunction

  function automatic lcdh_pkg::lcdh_level_t col_lvl(input logic fr, input logic d);
    unique case ({fr, d})
      2'b00: col_lvl = lcdh_pkg::lv_v3;
      2'b01: col_lvl = lcdh_pkg::lv_vdd;
      2'b10: col_lvl = lcdh_pkg::lv_v2;
      2'b11: col_lvl = lcdh_pkg::lv_v5;
    endcase
  endfunction

  // --------------------------------------------
  // host port
  // --------------------------------------------
  lcdh_strobe u_strobe (
    .clk_sys(clk_sys),
    .rst(rst),
    .mode68(mode68_q),
    .chip_sel(chip_sel),
    .strobe_e_rd(strobe_e_rd),
    .dir_rw_wr(dir_rw_wr),
    .cmd_data_sel(cmd_data_sel),
    .data_in(host_data_in),
    .bus(bus)
  );

  assign pin_edge = reset_if_pin ^ pin_prev_q; // R14
  assign cmd_wr = bus.wr_stb & ~bus.cd & ~srst_q; // R1
  assign data_wr = bus.wr_stb & bus.cd & ~srst_q; // R2
  assign data_rd_end = bus.rd_end & bus.cd;
  assign status = (8'(disp_on_q) << `LCDH_STAT_DISP) | (8'(mode68_q) << `LCDH_STAT_MODE)
      | (8'(master_sel) << `LCDH_STAT_MASTER); // R1
  assign rd_byte = bus.cd ? mem[row_addr_q][col_byte_q] : status; // R1 R2
  assign tick = ext_clock_in & ~clk_prev_q; // R11
  assign frame_use = master_sel ? frame_q : frame_polarity_in; // R15
  assign row_cnt_d = row_cnt_q + 4'h1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_prev_q <= 1'b0;
      srst_q <= 1'b1;
      mode68_q <= 1'b0;
    end else begin
      pin_prev_q <= reset_if_pin;
      srst_q <= pin_edge; // R14
      mode68_q <= reset_if_pin; // R14
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disp_on_q <= 1'b0;
      row_addr_q <= 5'h00;
      col_byte_q <= 4'h0;
    end else if (srst_q) begin
      disp_on_q <= 1'b0;
      row_addr_q <= 5'h00;
      col_byte_q <= 4'h0;
    end else if (cmd_wr) begin
      if (bus.wdata[7:5] == `LCDH_CMD_ROW_TAG) begin
        row_addr_q <= bus.wdata[4:0];
      end else if (bus.wdata[7:5] == `LCDH_CMD_DISP_TAG) begin
        disp_on_q <= bus.wdata[0];
      end else if (!bus.wdata[7] && bus.wdata[3:0] < 4'(`LCDH_MEM_BYTES)) begin
        col_byte_q <= bus.wdata[3:0];
      end
    end else if (data_wr | data_rd_end) begin
      col_byte_q <= next_byte(col_byte_q); // R2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (data_wr) begin
      mem[row_addr_q][col_byte_q] <= bus.wdata; // R2
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end else begin
      host_data_out <= rd_byte;
      host_data_oe <= bus.rd_active & ~srst_q; // R7 R8
    end
  end

  // --------------------------------------------
  // scan and drivers
  // --------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
      row_cnt_q <= 4'h0;
      frame_q <= 1'b0;
    end else begin
      clk_prev_q <= ext_clock_in;
      if (srst_q) begin
        row_cnt_q <= 4'h0;
        frame_q <= 1'b0;
      end else if (tick) begin
        row_cnt_q <= row_cnt_d; // R9
        if (row_cnt_q == 4'(`LCDH_ROWS - 1)) begin
          frame_q <= ~frame_q;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_polarity_out <= 1'b0;
      frame_polarity_oe <= 1'b0;
    end else begin
      frame_polarity_out <= frame_q;
      frame_polarity_oe <= master_sel & disp_on_q & ~srst_q; // R8 R15
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `LCDH_ROWS; i++) begin
        row_drivers[i] <= lcdh_pkg::lv_vdd;
      end
      for (int j = 0; j < `LCDH_COLS; j++) begin
        column_drivers[j] <= lcdh_pkg::lv_vdd;
      end
    end else begin
      for (int i = 0; i < `LCDH_ROWS; i++) begin
        if (disp_on_q && master_sel && !srst_q) begin
          row_drivers[i] <= row_lvl(frame_use, row_cnt_q == 4'(i)); // R9
        end else begin
          row_drivers[i] <= lcdh_pkg::lv_vdd; // R8 R13
        end
      end
      for (int j = 0; j < `LCDH_COLS; j++) begin
        if (disp_on_q && !srst_q && (!master_sel || j < `LCDH_MASTER_COLS)) begin
          column_drivers[j] <= col_lvl(frame_use, mem[{1'b0, row_cnt_q}][j / 8][j % 8]); // R10 R13
        end else begin
          column_drivers[j] <= lcdh_pkg::lv_vdd; // R8
        end
      end
    end
  end

  // --------------------------------------------
  // checks
  // --------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_bus_drive_rd: assert property (bus.rd_active && !srst_q |=> host_data_oe) // R7
    else $error("data bus not driven during read");
  chk_bus_float_idle: assert property (!bus.rd_active |=> !host_data_oe) // R7
    else $error("data bus driven outside a read");
  chk_reset_outputs: assert property (srst_q |=> !host_data_oe && !frame_polarity_oe
      && row_drivers[0] == lcdh_pkg::lv_vdd && column_drivers[0] == lcdh_pkg::lv_vdd) // R8
    else $error("outputs not at reset state");
  chk_status_read: assert property (bus.rd_active && !bus.cd |=> host_data_out == $past(status)) // R1
    else $error("status not returned on command read");
  chk_data_store: assert property (data_wr |=> mem[$past(row_addr_q)][$past(col_byte_q)]
      == $past(bus.wdata)) // R2
    else $error("display write not stored");
  chk_pin_edge_reset: assert property (pin_edge |=> srst_q ##1 mode68_q == $past(reset_if_pin, 2)) // R14
    else $error("reset pin edge not acted on");
  chk_row_level: assert property (disp_on_q && master_sel && !srst_q |=>
      row_drivers[$past(row_cnt_q)] == ($past(frame_use) ? lcdh_pkg::lv_vdd : lcdh_pkg::lv_v5)) // R9
    else $error("active row level wrong");
  chk_col_level: assert property (disp_on_q && !srst_q |=>
      column_drivers[0] == col_lvl($past(frame_use), $past(mem[{1'b0, row_cnt_q}][0][0]))) // R10
    else $error("column level wrong");
  chk_tick_advance: assert property (tick && !srst_q |=> row_cnt_q == $past(row_cnt_d)) // R11
    else $error("row counter missed clock");
  chk_frame_slave: assert property (!master_sel |=> !frame_polarity_oe) // R15
    else $error("slave drives frame pin");
  chk_slave_cols: assert property (master_sel |=> column_drivers[`LCDH_COLS - 1] == lcdh_pkg::lv_vdd) // R13
    else $error("row pad used as column on master");

  cov_data_write: cover property (data_wr);
  cov_status_read: cover property (bus.rd_end && !bus.cd);
  cov_frame_flip: cover property (tick && row_cnt_q == 4'(`LCDH_ROWS - 1));
endmodule

// file: design/lcdh_defines.svh
// constants of the lcd driver host port
`ifndef LCDH_DEFINES_SVH
`define LCDH_DEFINES_SVH
`define LCDH_ROWS 16
`define LCDH_COLS 80
`define LCDH_MEM_ROWS 32
`define LCDH_MEM_BYTES 10
`define LCDH_MASTER_COLS 61
`define LCDH_CMD_ROW_TAG 3'h6
`define LCDH_CMD_DISP_TAG 3'h5
`define LCDH_STAT_BUSY 7
`define LCDH_STAT_DISP 6
`define LCDH_STAT_MODE 5
`define LCDH_STAT_MASTER 4
`endif

// file: design/lcdh_pkg.sv
// types shared by the lcd driver host port
package lcdh_pkg;
  typedef enum logic [2:0] {lv_vdd, lv_v1, lv_v2, lv_v3, lv_v4, lv_v5} lcdh_level_t;
endpackage

// file: design/lcdh_bus_if.sv
// decoded host accesses between strobe decoder and core
`timescale 1ns/1ps
interface lcdh_bus_if;
  logic wr_stb;
  logic rd_active;
  logic rd_end;
  logic cd;
  logic [7:0] wdata;
  modport decoder (output wr_stb, output rd_active, output rd_end, output cd, output wdata);
  modport core (input wr_stb, input rd_active, input rd_end, input cd, input wdata);
endinterface

// file: design/lcdh_strobe.sv
// 68-type and 80-type strobe decoder
`timescale 1ns/1ps
module lcdh_strobe (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode68,
  input wire logic chip_sel,
  input wire logic strobe_e_rd,
  input wire logic dir_rw_wr,
  input wire logic cmd_data_sel,
  input wire logic [7:0] data_in,
  lcdh_bus_if.decoder bus
);
  logic wr_act;
  logic rd_act;
  logic wr_act_q;
  logic rd_act_q;
  logic cd_q;
  logic [7:0] din_q;

  // --------------------------------------------
  // access decode
  // --------------------------------------------
  assign wr_act = mode68 ? (chip_sel & strobe_e_rd & ~dir_rw_wr) // R3 R5
                         : (chip_sel & ~dir_rw_wr); // R6
  assign rd_act = mode68 ? (chip_sel & strobe_e_rd & dir_rw_wr) // R3 R5
                         : (chip_sel & ~strobe_e_rd); // R4
  assign bus.wr_stb = wr_act_q & ~wr_act;
  assign bus.rd_active = rd_act;
  assign bus.rd_end = rd_act_q & ~rd_act;
  assign bus.cd = (wr_act | rd_act) ? cmd_data_sel : cd_q;
  assign bus.wdata = din_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      cd_q <= 1'b0;
      din_q <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act | rd_act) begin
        cd_q <= cmd_data_sel;
      end
      if (wr_act) begin
        din_q <= data_in;
      end
    end
  end

  // --------------------------------------------
  // checks
  // --------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_rd68_sel: assert property (mode68 && chip_sel && strobe_e_rd && dir_rw_wr |-> bus.rd_active) // R3
    else $error("68-type read not recognised");
  chk_wr68_fall: assert property (mode68 && chip_sel && strobe_e_rd && !dir_rw_wr ##1 mode68 && !strobe_e_rd |-> bus.wr_stb && bus.wdata == $past(data_in)) // R5
    else $error("68-type write not taken on enable fall");
  chk_rd80_low: assert property (!mode68 && chip_sel && !strobe_e_rd |-> bus.rd_active) // R4
    else $error("80-type read not recognised");
  chk_wr80_rise: assert property (!mode68 && chip_sel && !dir_rw_wr ##1 !mode68 && dir_rw_wr |-> bus.wr_stb) // R6
    else $error("80-type write not taken on write rise");
endmodule

// file: tb/lcdh_host_model.sv
// host microcontroller model driving the 8-bit parallel port
`timescale 1ns/1ps
module lcdh_host_model (
  input wire logic clk_sys,
  input wire logic mode68,
  output logic chip_sel,
  output logic cmd_data_sel,
  output logic strobe_e_rd,
  output logic dir_rw_wr,
  output wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  logic [7:0] drv_q;
  logic drv_en;

  // ----------------------------------------
  // bus wire and access task
  // ----------------------------------------
  // a released bus shows the inverse of the last byte, never a stale copy
  assign host_data_in = host_data_oe ? host_data_out : (drv_en ? drv_q : ~drv_q);

  initial begin
    chip_sel = 1'b0;
    cmd_data_sel = 1'b0;
    strobe_e_rd = 1'b1;
    dir_rw_wr = 1'b1;
    drv_q = 8'h00;
    drv_en = 1'b0;
  end

  task automatic xfer(input logic rd, input logic cd, input logic sel, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic seen);
    int n;
    seen = 1'b0;
    rdat = 8'h00;
    @(posedge clk_sys);
    chip_sel <= sel;
    cmd_data_sel <= cd;
    strobe_e_rd <= mode68 | ~rd;
    dir_rw_wr <= rd;
    drv_q <= wd;
    drv_en <= ~rd;
    for (n = 0; n < (rd ? 4 : 1) && !seen; n++) begin
      @(posedge clk_sys);
      if (host_data_oe === 1'b1) begin
        seen = 1'b1;
        rdat = host_data_out;
      end
    end
    chip_sel <= 1'b0;
    strobe_e_rd <= ~mode68;
    dir_rw_wr <= 1'b1;
    drv_en <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the lcd driver host port
`timescale 1ns/1ps
`include "lcdh_defines.svh"
module testbench;
  logic clk_sys, rst, reset_if_pin, master_sel, ext_clock_in, frame_polarity_in, mode68;
  logic chip_sel, cmd_data_sel, strobe_e_rd, dir_rw_wr, host_data_oe;
  logic frame_polarity_out, frame_polarity_oe, seen, disp, fr;
  wire [7:0] host_data_in;
  logic [7:0] host_data_out, rd_q;
  lcdh_pkg::lcdh_level_t row_drivers [`LCDH_ROWS];
  lcdh_pkg::lcdh_level_t column_drivers [`LCDH_COLS];
  logic [7:0] mem [16][10];
  int seed, fail_count, samples_checked, cnt, r, b;

  lcdh_top dut_u (.clk_sys, .rst, .reset_if_pin, .chip_sel, .cmd_data_sel, .strobe_e_rd,
    .dir_rw_wr, .master_sel, .ext_clock_in, .host_data_in, .host_data_out, .host_data_oe,
    .frame_polarity_in, .frame_polarity_out, .frame_polarity_oe, .row_drivers, .column_drivers);
  lcdh_host_model host_u (.clk_sys, .mode68, .chip_sel, .cmd_data_sel, .strobe_e_rd,
    .dir_rw_wr, .host_data_in, .host_data_out, .host_data_oe);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic lcdh_pkg::lcdh_level_t col_lvl(input logic f, input logic d);
    return f ? (d ? lcdh_pkg::lv_v5 : lcdh_pkg::lv_v2) : (d ? lcdh_pkg::lv_vdd : lcdh_pkg::lv_v3);
  endfunction

  function automatic lcdh_pkg::lcdh_level_t row_lvl(input logic f, input logic s);
    return f ? (s ? lcdh_pkg::lv_vdd : lcdh_pkg::lv_v1) : (s ? lcdh_pkg::lv_v5 : lcdh_pkg::lv_v4);
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic cd, input logic [7:0] d);
    host_u.xfer(1'b0, cd, 1'b1, d, rd_q, seen);
  endtask

  task automatic rdchk(input logic cd, input logic [7:0] exp);
    host_u.xfer(1'b1, cd, 1'b1, 8'h00, rd_q, seen);
    check("read oe", 8'h01, {7'h00, seen});
    check("read data", exp, rd_q);
  endtask

  task automatic scan();
    lcdh_pkg::lcdh_level_t e;
    for (int c = 0; c < `LCDH_COLS; c++) begin
      e = (!disp || (master_sel && c >= `LCDH_MASTER_COLS)) ? lcdh_pkg::lv_vdd :
          col_lvl(fr, mem[cnt][c / 8][c % 8]);
      check("column", 8'(e), 8'(column_drivers[c]));
    end
    for (int i = 0; i < `LCDH_ROWS; i++) begin
      e = (!disp || !master_sel) ? lcdh_pkg::lv_vdd : row_lvl(fr, i == cnt);
      check("row", 8'(e), 8'(row_drivers[i]));
    end
    check("frame oe", {7'h00, disp & master_sel}, {7'h00, frame_polarity_oe});
    if (disp && master_sel) begin
      check("frame", {7'h00, fr}, {7'h00, frame_polarity_out});
    end
  endtask

  task automatic tick();
    ext_clock_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_clock_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cnt = (cnt + 1) % 16;
    if (master_sel && cnt == 0) begin
      fr = ~fr;
    end
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end

  initial begin
    seed = 13;
    rst = 1'b1;
    reset_if_pin = 1'b0;
    master_sel = 1'b0;
    ext_clock_in = 1'b0;
    frame_polarity_in = 1'b0;
    mode68 = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    cnt = 0;
    disp = 1'b0;
    fr = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    scan();
    check("data oe", 8'h00, {7'h00, host_data_oe});
    rdchk(1'b0, 8'h00);
    for (r = 0; r < 16; r++) begin
      wr(1'b0, 8'hC0 | 8'(r));
      wr(1'b0, 8'h00);
      for (b = 0; b < 11; b++) begin
        mem[r][b % 10] = 8'($random(seed));
        wr(1'b1, mem[r][b % 10]);
      end
    end
    r = {$random(seed)} % 16;
    wr(1'b0, 8'hC0 | 8'(r));
    wr(1'b0, 8'h09);
    rdchk(1'b1, mem[r][9]);
    rdchk(1'b1, mem[r][0]);
    host_u.xfer(1'b1, 1'b1, 1'b0, 8'h00, rd_q, seen);
    check("unselected oe", 8'h00, {7'h00, seen});
    wr(1'b0, 8'hA1);
    disp = 1'b1;
    rdchk(1'b0, 8'h40);
    repeat (2) begin
      frame_polarity_in <= fr;
      repeat (16) begin
        tick();
        scan();
      end
      fr = ~fr;
    end
    wr(1'b0, 8'h0C);
    rdchk(1'b1, mem[r][1]);
    wr(1'b0, 8'hA0);
    disp = 1'b0;
    repeat (2) @(posedge clk_sys);
    scan();
    rdchk(1'b0, 8'h00);
    master_sel <= 1'b1;
    reset_if_pin <= 1'b1;
    mode68 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cnt = 0;
    disp = 1'b0;
    scan();
    rdchk(1'b0, 8'h30);
    wr(1'b0, 8'hC0 | 8'(r));
    wr(1'b0, 8'h00);
    rdchk(1'b1, mem[r][0]);
    mem[r][1] = 8'($random(seed));
    wr(1'b1, mem[r][1]);
    wr(1'b0, 8'h01);
    rdchk(1'b1, mem[r][1]);
    wr(1'b0, 8'hA1);
    disp = 1'b1;
    @(posedge clk_sys);
    // frame polarity restarts low after the soft reset
    fr = 1'b0;
    repeat (17) begin
      tick();
      scan();
    end
    conclude();
  end
endmodule
